// ===== cpu_flags_defines.svh
// Constants for the flag and flow-control block: opcodes, vectors,
// flag bit positions, reset values.
// Assumes inclusion by bare name from design files.
`ifndef CPU_FLAGS_DEFINES_SVH
`define CPU_FLAGS_DEFINES_SVH

// Flag bit positions in the flag byte
`define FLG_C 0
`define FLG_N 1
`define FLG_PV 2
`define FLG_H 4
`define FLG_Z 6
`define FLG_S 7
// Flag register reset value
`define FLAGS_RST 8'h00
// Meaningful flag bits
`define FLAGS_MASK 8'hd7
// Restart opcode pattern: 11 ttt 111
`define RST_OP_MASK 8'hc7
`define RST_OP_BASE 8'hc7
// Fixed vector of interrupt mode 1
`define IRQ_FIXED_VEC 16'h0038
// Prefixed opcodes (second byte after the ed prefix)
`define OP_PREFIX_ED 8'hed
`define OP_RET_MASK 8'h4d
`define OP_RET_NMI 8'h45
`define OP_IM0 8'h46
`define OP_IM1 8'h56
`define OP_IM2 8'h5e
// Loop branch instruction length in bytes
`define LOOP_LEN 16'h0002

`endif

// ===== cpu_flags_pkg.sv
// Types for the flag and flow-control block.
// Assumes the defines header is compiled alongside.
package cpu_flags_pkg;

    // Operation class presented with each commit
    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_ADD = 4'b0001,
        OP_SUB = 4'b0010,
        OP_CMP = 4'b0011,
        OP_NEG = 4'b0100,
        OP_AND = 4'b0101,
        OP_OR = 4'b0110,
        OP_XOR = 4'b0111,
        OP_SHIFT = 4'b1000,
        OP_DADJ = 4'b1001,
        OP_BIT = 4'b1010,
        OP_BLK_MOVE = 4'b1011,
        OP_BLK_SEARCH = 4'b1100,
        OP_BLK_IO = 4'b1101,
        OP_LD_A_IR = 4'b1110
    } alu_op_t;

    // Branch condition codes
    typedef enum logic [3:0] {
        CC_ALWAYS = 4'b0000,
        CC_NC = 4'b0001,
        CC_C = 4'b0010,
        CC_NZ = 4'b0011,
        CC_Z = 4'b0100,
        CC_PO = 4'b0101,
        CC_PE = 4'b0110,
        CC_P = 4'b0111,
        CC_M = 4'b1000,
        CC_LOOP = 4'b1001
    } cond_t;

    // Interrupt response mode
    typedef enum logic [1:0] {
        IRQ_MODE_BUS = 2'b00,
        irq_mode_fixed_vector = 2'b01,
        irq_mode_vector_table = 2'b10
    } irq_mode_t;

    // I/O address source
    typedef enum logic [1:0] {
        IO_NONE = 2'b00,
        IO_IMMEDIATE = 2'b01,
        IO_REG_INDIRECT = 2'b10,
        IO_BLOCK = 2'b11
    } io_kind_t;

endpackage : cpu_flags_pkg

// ===== flag_alu.sv
// Combinational flag and result generator for one 8-bit operation.
// Assumes operands are stable for the commit cycle.
`timescale 1ns/1ps
`include "cpu_flags_defines.svh"

module flag_alu (
    // Operation
    input wire cpu_flags_pkg::alu_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] operand,
    input wire logic carry_in,
    input wire logic use_carry,
    input wire logic [2:0] bit_sel,
    // Present flags, used by decimal adjust and side cases
    input wire logic [7:0] flags_in,
    input wire logic [15:0] bc_after,
    input wire logic [7:0] b_after,
    input wire logic irq_enable_latch,
    // Results
    output logic [7:0] result,
    output logic [7:0] flags_out
);

    logic [8:0] sum9;
    logic [4:0] half5;
    logic cin;
    logic c;
    logic h;
    logic v;
    logic n;
    logic [7:0] corr;
    logic [7:0] src;
    logic [7:0] lhs;

    ////////////////////////////////////////////////////////////////////
    // Adder core, shared by add, subtract, compare and negate
    always_comb begin
        cin = use_carry & carry_in;
        lhs = (op == cpu_flags_pkg::OP_NEG) ? 8'h00 : acc;
        src = (op == cpu_flags_pkg::OP_NEG) ? acc : operand;
        if (op == cpu_flags_pkg::OP_ADD) begin
            sum9 = {1'b0, lhs} + {1'b0, src} + {8'h00, cin};
            half5 = {1'b0, lhs[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
        end else begin
            sum9 = {1'b0, lhs} - {1'b0, src} - {8'h00, cin};
            half5 = {1'b0, lhs[3:0]} - {1'b0, src[3:0]} - {4'h0, cin};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Result and flags per operation class
    always_comb begin
        result = acc;
        c = flags_in[`FLG_C];
        h = flags_in[`FLG_H];
        v = flags_in[`FLG_PV];
        n = flags_in[`FLG_N];
        corr = 8'h00;
        unique case (op)
            cpu_flags_pkg::OP_ADD, cpu_flags_pkg::OP_SUB,
            cpu_flags_pkg::OP_CMP, cpu_flags_pkg::OP_NEG: begin
                result = sum9[7:0];
                c = sum9[8];
                h = half5[4];
                n = (op != cpu_flags_pkg::OP_ADD);
                // Overflow: sign of result disagrees with operands
                if (op == cpu_flags_pkg::OP_ADD) begin
                    v = (lhs[7] == src[7]) && (sum9[7] != lhs[7]);
                end else begin
                    v = (lhs[7] != src[7]) && (sum9[7] != lhs[7]);
                end
            end
            cpu_flags_pkg::OP_AND, cpu_flags_pkg::OP_OR,
            cpu_flags_pkg::OP_XOR: begin
                if (op == cpu_flags_pkg::OP_AND) begin
                    result = acc & operand;
                end else if (op == cpu_flags_pkg::OP_OR) begin
                    result = acc | operand;
                end else begin
                    result = acc ^ operand;
                end
                c = 1'b0;
                h = (op == cpu_flags_pkg::OP_AND);
                n = 1'b0;
                v = ~^result;
            end
            cpu_flags_pkg::OP_SHIFT: begin
                // Rotate left through carry stands for the shift group
                result = {operand[6:0], carry_in};
                c = operand[7];
                h = 1'b0;
                n = 1'b0;
                v = ~^result;
            end
            cpu_flags_pkg::OP_DADJ: begin
                // Correction chosen from H, C and the nibble values; N picks add or subtract
                if (flags_in[`FLG_H] || acc[3:0] > 4'h9) begin
                    corr[3:0] = 4'h6;
                end
                if (flags_in[`FLG_C] || acc > 8'h99) begin
                    corr[7:4] = 4'h6;
                    c = 1'b1;
                end else begin
                    c = 1'b0;
                end
                if (flags_in[`FLG_N]) begin
                    result = acc - corr;
                    h = flags_in[`FLG_H] && (acc[3:0] < 4'h6);
                end else begin
                    result = acc + corr;
                    h = acc[3:0] > 4'h9;
                end
                v = ~^result;
            end
            cpu_flags_pkg::OP_BIT: begin
                result = acc;
                h = 1'b1;
                n = 1'b0;
            end
            cpu_flags_pkg::OP_BLK_MOVE: begin
                h = 1'b0;
                n = 1'b0;
                v = (bc_after != 16'h0000);
            end
            cpu_flags_pkg::OP_BLK_SEARCH: begin
                result = acc - operand;
                n = 1'b1;
                v = (bc_after != 16'h0000);
            end
            cpu_flags_pkg::OP_BLK_IO: begin
                n = 1'b1;
            end
            cpu_flags_pkg::OP_LD_A_IR: begin
                result = operand;
                v = irq_enable_latch;
                h = 1'b0;
                n = 1'b0;
            end
            default: begin
                result = acc;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Pack the flag byte; zero and sign follow the result by default
    always_comb begin
        flags_out = flags_in;
        flags_out[`FLG_C] = c;
        flags_out[`FLG_H] = h;
        flags_out[`FLG_PV] = v;
        flags_out[`FLG_N] = n;
        flags_out[`FLG_S] = result[7];
        flags_out[`FLG_Z] = (result == 8'h00);
        if (op == cpu_flags_pkg::OP_BIT) begin
            flags_out[`FLG_Z] = ~operand[bit_sel];
            flags_out[`FLG_S] = flags_in[`FLG_S];
        end else if (op == cpu_flags_pkg::OP_BLK_SEARCH) begin
            flags_out[`FLG_Z] = (acc == operand);
        end else if (op == cpu_flags_pkg::OP_BLK_IO) begin
            flags_out[`FLG_Z] = (b_after == 8'h00);
        end else if (op == cpu_flags_pkg::OP_BLK_MOVE) begin
            flags_out[`FLG_Z] = flags_in[`FLG_Z];
            flags_out[`FLG_S] = flags_in[`FLG_S];
        end
        flags_out = flags_out & `FLAGS_MASK;
    end

endmodule : flag_alu

// ===== cpu_flags_branch_io_control.sv
// Flag registers, branch decisions, restart and interrupt vectors and
// I/O address formation for an 8-bit core.
// Assumes decode elsewhere presents one committed operation per cycle.
//
// How it works
// - Loop branch decrements B, jumps unless zero
// - Restart opcodes call vectors zero to 0x38
// - Immediate I/O: port low, accumulator high
// - Indirect I/O: C low, B high
// - Block I/O: HL pointer, B count, C port
// - Mode one answers interrupts at 0x0038
// - Mode two pointer from I and peripheral
// - Two return opcodes pop return address
// - Two flag registers; four bits are testable
// - Carry from top bit, borrow, shifts
// - Zero set when result is zero
// - Sign copies result top bit
// - Overflow flags signed range violation
// - Logical ops put even parity in P/V
// - Half carry records nibble carry or borrow
// - Subtract flag set on subtract, cleared add
// - Decimal adjust uses half carry, subtract
// - Block search: zero on match, P/V BC
// - Block I/O sets N, zero when B=0
// - Load A from I/R copies enable latch
// - Bit test: zero when selected bit clear
`timescale 1ns/1ps
`include "cpu_flags_defines.svh"

module cpu_flags_branch_io_control (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Operation commit
    input wire logic op_commit,
    input wire cpu_flags_pkg::alu_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] operand,
    input wire logic use_carry,
    input wire logic [2:0] bit_sel,
    input wire logic [15:0] bc_after,
    input wire logic irq_enable_latch,
    input wire logic swap_flags,
    // Register file view
    input wire logic [7:0] reg_b,
    input wire logic [7:0] reg_c,
    input wire logic [15:0] reg_hl,
    input wire logic [7:0] reg_i,
    // Branch request
    input wire logic branch_req,
    input wire cpu_flags_pkg::cond_t cond,
    input wire logic [15:0] pc_next,
    input wire logic [15:0] target,
    input wire logic [7:0] disp,
    // Opcode stream for restarts, returns and mode changes
    input wire logic opcode_valid,
    input wire logic ed_prefixed,
    input wire logic [7:0] opcode,
    input wire logic [15:0] pop_addr,
    // Interrupt acceptance
    input wire logic irq_ack,
    input wire logic [7:0] irq_vector_byte,
    // I/O request
    input wire cpu_flags_pkg::io_kind_t io_kind,
    input wire logic [7:0] io_port,
    // Results
    output logic [7:0] result_q,
    output logic [7:0] flags_q,
    output logic [7:0] flags_alt_q,
    output logic [7:0] b_q,
    output logic pc_load_q,
    output logic [15:0] pc_q,
    output logic push_ret_q,
    output logic [15:0] ret_addr_q,
    output logic table_fetch_q,
    output logic nmi_return_q,
    output cpu_flags_pkg::irq_mode_t irq_mode_q,
    output logic [15:0] io_addr_q,
    output logic [15:0] io_mem_ptr_q
);

    logic [7:0] alu_result;
    logic [7:0] alu_flags;
    logic [7:0] b_dec;
    logic cond_true;
    logic [15:0] rel_target;
    logic is_restart;
    logic [15:0] rst_vec;
    logic [7:0] flags_d;

    ////////////////////////////////////////////////////////////////////
    // Flag computation for the committed operation
    flag_alu u_alu (
        .op(op),
        .acc(acc),
        .operand(operand),
        .carry_in(flags_q[`FLG_C]),
        .use_carry(use_carry),
        .bit_sel(bit_sel),
        .flags_in(flags_q),
        .bc_after(bc_after),
        .b_after(b_dec),
        .irq_enable_latch(irq_enable_latch),
        .result(alu_result),
        .flags_out(alu_flags)
    );

    // Block I/O and the loop branch both count B down by one
    assign b_dec = reg_b - 8'h01;

    ////////////////////////////////////////////////////////////////////
    // Condition decode; only C, Z, P/V and S are testable
    always_comb begin
        unique case (cond)
            cpu_flags_pkg::CC_ALWAYS: cond_true = 1'b1;
            cpu_flags_pkg::CC_NC: cond_true = ~flags_q[`FLG_C];
            cpu_flags_pkg::CC_C: cond_true = flags_q[`FLG_C];
            cpu_flags_pkg::CC_NZ: cond_true = ~flags_q[`FLG_Z];
            cpu_flags_pkg::CC_Z: cond_true = flags_q[`FLG_Z];
            cpu_flags_pkg::CC_PO: cond_true = ~flags_q[`FLG_PV];
            cpu_flags_pkg::CC_PE: cond_true = flags_q[`FLG_PV];
            cpu_flags_pkg::CC_P: cond_true = ~flags_q[`FLG_S];
            cpu_flags_pkg::CC_M: cond_true = flags_q[`FLG_S];
            cpu_flags_pkg::CC_LOOP: cond_true = (b_dec != 8'h00);
            default: cond_true = 1'b0;
        endcase
    end

    // Relative target: pc_next already points past the two bytes
    assign rel_target = pc_next + {{8{disp[7]}}, disp};

    // Restart: 11 ttt 111, vector is ttt times eight
    assign is_restart = ~ed_prefixed &&
        ((opcode & `RST_OP_MASK) == `RST_OP_BASE);
    assign rst_vec = {10'h000, opcode[5:3], 3'b000};

    ////////////////////////////////////////////////////////////////////
    // Flag registers: main and alternate; flags land with the result
    always_comb begin
        flags_d = flags_q;
        if (op_commit) begin
            flags_d = alu_flags;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= `FLAGS_RST;
            flags_alt_q <= `FLAGS_RST;
        end else if (swap_flags) begin
            // Exchange wins over a commit in the same cycle
            flags_q <= flags_alt_q;
            flags_alt_q <= flags_q;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Committed result
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            result_q <= 8'h00;
        end else if (op_commit) begin
            result_q <= alu_result;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // B counter: loop branch and block I/O both decrement it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            b_q <= 8'h00;
        end else if ((branch_req && cond == cpu_flags_pkg::CC_LOOP) ||
                (op_commit && op == cpu_flags_pkg::OP_BLK_IO)) begin
            b_q <= b_dec;
        end else begin
            b_q <= reg_b;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Program counter steering; priority: interrupt, opcode, branch
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pc_load_q <= 1'b0;
            pc_q <= 16'h0000;
            push_ret_q <= 1'b0;
            ret_addr_q <= 16'h0000;
            table_fetch_q <= 1'b0;
            nmi_return_q <= 1'b0;
        end else begin
            pc_load_q <= 1'b0;
            push_ret_q <= 1'b0;
            table_fetch_q <= 1'b0;
            nmi_return_q <= 1'b0;
            pc_q <= pc_next;
            if (irq_ack && irq_mode_q ==
                    cpu_flags_pkg::irq_mode_fixed_vector) begin
                pc_load_q <= 1'b1;
                pc_q <= `IRQ_FIXED_VEC;
                push_ret_q <= 1'b1;
                ret_addr_q <= pc_next;
            end else if (irq_ack && irq_mode_q ==
                    cpu_flags_pkg::irq_mode_vector_table) begin
                // Pointer into the vector table; caller fetches through it
                pc_q <= {reg_i, irq_vector_byte};
                table_fetch_q <= 1'b1;
                push_ret_q <= 1'b1;
                ret_addr_q <= pc_next;
            end else if (opcode_valid && is_restart) begin
                pc_load_q <= 1'b1;
                pc_q <= rst_vec;
                push_ret_q <= 1'b1;
                ret_addr_q <= pc_next;
            end else if (opcode_valid && ed_prefixed &&
                    (opcode == `OP_RET_MASK ||
                    opcode == `OP_RET_NMI)) begin
                pc_load_q <= 1'b1;
                pc_q <= pop_addr;
                nmi_return_q <= (opcode == `OP_RET_NMI);
            end else if (branch_req && cond_true) begin
                pc_load_q <= 1'b1;
                if (cond == cpu_flags_pkg::CC_LOOP) begin
                    pc_q <= rel_target;
                end else begin
                    pc_q <= target;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt mode selection by the ed-prefixed mode opcodes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_mode_q <= cpu_flags_pkg::IRQ_MODE_BUS;
        end else if (opcode_valid && ed_prefixed) begin
            if (opcode == `OP_IM1) begin
                irq_mode_q <= cpu_flags_pkg::irq_mode_fixed_vector;
            end else if (opcode == `OP_IM2) begin
                irq_mode_q <= cpu_flags_pkg::irq_mode_vector_table;
            end else if (opcode == `OP_IM0) begin
                irq_mode_q <= cpu_flags_pkg::IRQ_MODE_BUS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // I/O address bus; held between accesses
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            io_addr_q <= 16'h0000;
            io_mem_ptr_q <= 16'h0000;
        end else begin
            unique case (io_kind)
                cpu_flags_pkg::IO_NONE: begin
                    io_addr_q <= io_addr_q;
                end
                cpu_flags_pkg::IO_IMMEDIATE: begin
                    io_addr_q <= {acc, io_port};
                end
                cpu_flags_pkg::IO_REG_INDIRECT: begin
                    io_addr_q <= {reg_b, reg_c};
                end
                cpu_flags_pkg::IO_BLOCK: begin
                    io_addr_q <= {reg_b, reg_c};
                    io_mem_ptr_q <= reg_hl;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_restart_seen;
        opcode_valid && is_restart && !irq_ack;
    endsequence

    a_restart_vector: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_restart_seen |=> pc_load_q && push_ret_q &&
        pc_q == {10'h000, $past(opcode[5:3]), 3'b000})
        else $error("restart vector wrong");

    a_fixed_irq_vec: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq_ack && irq_mode_q == cpu_flags_pkg::irq_mode_fixed_vector
        |=> pc_q == 16'h0038 && pc_load_q)
        else $error("mode one vector wrong");

    a_table_pointer: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq_ack && irq_mode_q == cpu_flags_pkg::irq_mode_vector_table
        |=> table_fetch_q && pc_q == {$past(reg_i), $past(irq_vector_byte)})
        else $error("mode two pointer wrong");

    a_io_immediate: assert property (@(posedge ref_clk) disable iff (!rstn)
        io_kind == cpu_flags_pkg::IO_IMMEDIATE
        |=> io_addr_q == {$past(acc), $past(io_port)})
        else $error("immediate io address wrong");

    a_io_indirect: assert property (@(posedge ref_clk) disable iff (!rstn)
        io_kind inside {cpu_flags_pkg::IO_REG_INDIRECT,
        cpu_flags_pkg::IO_BLOCK}
        |=> io_addr_q == {$past(reg_b), $past(reg_c)})
        else $error("indirect io address wrong");

    a_zero_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
        op_commit && !swap_flags && op inside {cpu_flags_pkg::OP_ADD,
        cpu_flags_pkg::OP_SUB, cpu_flags_pkg::OP_AND}
        |=> flags_q[`FLG_Z] == (result_q == 8'h00)
        && flags_q[`FLG_S] == result_q[7])
        else $error("zero or sign flag wrong");

    a_loop_branch: assert property (@(posedge ref_clk) disable iff (!rstn)
        branch_req && cond == cpu_flags_pkg::CC_LOOP && reg_b == 8'h01
        && !irq_ack && !opcode_valid |=> !pc_load_q)
        else $error("loop taken at zero");

    a_subtract_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
        op_commit && !swap_flags && op inside {cpu_flags_pkg::OP_SUB,
        cpu_flags_pkg::OP_CMP, cpu_flags_pkg::OP_NEG} |=> flags_q[`FLG_N])
        else $error("subtract flag not set");

    a_not_taken: assert property (@(posedge ref_clk) disable iff (!rstn)
        branch_req && !cond_true && !irq_ack && !opcode_valid
        |=> !pc_load_q && pc_q == $past(pc_next))
        else $error("false branch moved pc");

endmodule : cpu_flags_branch_io_control

// ===== mem_io_model.sv
// Stack memory and interrupting peripheral on the far side of the block.
// Assumes pushes arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ps

module mem_io_model #(
    parameter logic [7:0] VEC_BYTE = 8'h40
) (
    // Core side
    input wire logic ref_clk,
    input wire logic push_ret_q,
    input wire logic [15:0] ret_addr_q,
    // Answers from memory and the peripheral
    output logic [15:0] pop_addr,
    output logic [7:0] irq_vector_byte
);
    // Single-entry stack top; nesting deeper than one is not exercised
    always_ff @(posedge ref_clk) begin
        if (push_ret_q) pop_addr <= ret_addr_q;
    end
    // Even byte, so either table-pointer reading gives the same address
    assign irq_vector_byte = VEC_BYTE;
endmodule : mem_io_model

// ===== tb.sv
// Self-checking bench for the flag and flow-control block.
// Assumes registered outputs one cycle after the request edge.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module tb;
    logic ref_clk = 1'b0, rstn = 1'b0;
    logic op_commit, use_carry, irq_enable_latch, swap_flags, branch_req;
    logic opcode_valid, ed_prefixed, irq_ack, pc_load_q, push_ret_q;
    logic table_fetch_q, nmi_return_q;
    logic [2:0] bit_sel;
    logic [7:0] acc, operand, reg_b, reg_c, reg_i, disp, opcode, io_port;
    logic [7:0] irq_vector_byte, result_q, flags_q, flags_alt_q, b_q, a, b;
    logic [7:0] r, e;
    logic [15:0] bc_after, reg_hl, pc_next, target, pop_addr, pc_q, t;
    logic [15:0] ret_addr_q, io_addr_q, io_mem_ptr_q;
    logic [31:0] seed = 32'h00003395;
    cpu_flags_pkg::alu_op_t op;
    cpu_flags_pkg::cond_t cond;
    cpu_flags_pkg::io_kind_t io_kind;
    cpu_flags_pkg::irq_mode_t irq_mode_q;
    int fails = 0, num_checks = 0, i;

    cpu_flags_branch_io_control DUT (.*);
    mem_io_model partner (.ref_clk(ref_clk), .push_ret_q(push_ret_q),
        .ret_addr_q(ret_addr_q), .pop_addr(pop_addr),
        .irq_vector_byte(irq_vector_byte));

    ////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    // Expected add or subtract flags, no carry in
    function automatic logic [7:0] af(input logic [7:0] x, y, input logic s);
        logic [8:0] q;
        logic [4:0] h;
        q = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
        h = s ? {1'b0, x[3:0]} - {1'b0, y[3:0]}
              : {1'b0, x[3:0]} + {1'b0, y[3:0]};
        return {q[7], q[7:0] == 8'h00, 1'b0, h[4], 1'b0,
            (x[7] ^ s) == y[7] && q[7] != x[7], s, q[8]};
    endfunction : af

    // One edge, then drop every request strobe except swap_flags
    task automatic go();
        @(negedge ref_clk);
        {op_commit, branch_req, opcode_valid, ed_prefixed, irq_ack} = '0;
        io_kind = cpu_flags_pkg::IO_NONE;
    endtask : go

    // One commit for a cycle
    task automatic put(cpu_flags_pkg::alu_op_t o, logic [7:0] x, y);
        op = o;
        {acc, operand, op_commit} = {x, y, 1'b1};
        go();
    endtask : put

    task automatic give_verdict();
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        #4000000;
        fails++;
        give_verdict();
    end

    // Main sequence
    initial begin
        {use_carry, irq_enable_latch, swap_flags, bit_sel, bc_after} = '0;
        {acc, operand, reg_b, reg_c, reg_i, disp, opcode, io_port} = '0;
        {reg_hl, pc_next, target} = '0;
        op = cpu_flags_pkg::OP_NONE;
        cond = cpu_flags_pkg::CC_ALWAYS;
        go();
        repeat (4) @(negedge ref_clk);
        rstn = 1'b1;
        `CHK({flags_q, flags_alt_q}, 16'h0000)
        // Random arithmetic and logic, carry then tested by a branch
        for (i = 0; i < 60; i++) begin
            a = i == 0 ? 8'h78 : rnd();
            b = i == 0 ? 8'h69 : i == 1 ? a : rnd();
            op = cpu_flags_pkg::alu_op_t'(i % 5 < 2 ? i % 5 + 1 : i % 5 + 3);
            {acc, operand, op_commit} = {a, b, 1'b1};
            go();
            r = i % 5 == 0 ? a + b : i % 5 == 1 ? a - b : i % 5 == 2 ? a & b
                : i % 5 == 3 ? a | b : a ^ b;
            `CHK(result_q, r)
            e = i % 5 < 2 ? af(a, b, i % 5 == 1)
                          : {r[7], r == 8'h00, 3'b000, ~^r, 2'b00};
            `CHK(flags_q[0], e[0])
            `CHK(flags_q[6], e[6])
            `CHK(flags_q[7], e[7])
            `CHK(flags_q[2], e[2])
            if (i % 5 < 2) `CHK(flags_q[4], e[4])
            `CHK(flags_q[1], e[1])
            cond = cpu_flags_pkg::CC_C;
            {branch_req, pc_next, target} = {1'b1, rnd(), rnd(), rnd(), rnd()};
            go();
            `CHK(pc_load_q, e[0])
            `CHK(pc_q, e[0] ? target : pc_next)
        end
        // Each restart, then a return through the stack model
        for (i = 0; i < 8; i++) begin
            {opcode, opcode_valid} = {2'b11, i[2:0], 3'b111, 1'b1};
            pc_next = {rnd(), rnd()};
            t = pc_next;
            go();
            `CHK({pc_load_q, push_ret_q, pc_q}, {12'hc00, i[2:0], 3'b000})
            `CHK(ret_addr_q, t)
            go();
            opcode = i[0] ? 8'h45 : 8'h4d;
            {ed_prefixed, opcode_valid, pc_next} = {2'b11, ~t};
            go();
            `CHK({pc_load_q, pc_q, nmi_return_q}, {1'b1, t, i[0]})
        end
        // Loop branch, including the counts 0 and 1
        for (i = 0; i < 20; i++) begin
            {reg_b, disp, pc_next} = {i < 2 ? i[7:0] : rnd(), rnd(), rnd(), rnd()};
            cond = cpu_flags_pkg::CC_LOOP;
            branch_req = 1'b1;
            go();
            `CHK(b_q, reg_b - 8'h01)
            `CHK(pc_q, reg_b != 8'h01 ? pc_next + {{8{disp[7]}}, disp} : pc_next)
        end
        // Every I/O address source
        for (i = 1; i < 4; i++) begin
            {acc, io_port, reg_b, reg_c, reg_hl} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            io_kind = cpu_flags_pkg::io_kind_t'(i[1:0]);
            go();
            if (i == 1) `CHK(io_addr_q, {acc, io_port})
            else `CHK(io_addr_q, {reg_b, reg_c})
            if (i == 3) `CHK(io_mem_ptr_q, reg_hl)
        end
        // Fixed-vector then table interrupt modes
        {opcode, ed_prefixed, opcode_valid} = {8'h56, 2'b11};
        go();
        `CHK(irq_mode_q, cpu_flags_pkg::irq_mode_fixed_vector)
        irq_ack = 1'b1;
        go();
        `CHK({pc_load_q, pc_q}, {1'b1, 16'h0038})
        {opcode, ed_prefixed, opcode_valid, reg_i} = {8'h5e, 2'b11, rnd()};
        go();
        irq_ack = 1'b1;
        go();
        `CHK({table_fetch_q, pc_q}, {1'b1, reg_i, irq_vector_byte})
        bit_sel = 3'h4;
        put(cpu_flags_pkg::OP_BIT, 8'h00, 8'hef);
        `CHK(flags_q[6], 1'b1)
        irq_enable_latch = 1'b1;
        put(cpu_flags_pkg::OP_LD_A_IR, 8'h00, 8'h80);
        `CHK({result_q, flags_q[4], flags_q[2:1]}, 11'h402)
        reg_b = 8'h01;
        put(cpu_flags_pkg::OP_BLK_IO, 8'h00, 8'h00);
        `CHK({flags_q[6], flags_q[1]}, 2'b11)
        bc_after = 16'h0001;
        put(cpu_flags_pkg::OP_BLK_MOVE, 8'h00, 8'h00);
        `CHK(flags_q[2], 1'b1)
        put(cpu_flags_pkg::OP_BLK_SEARCH, 8'h5a, 8'h5a);
        `CHK({flags_q[6], flags_q[2]}, 2'b11)
        {e, swap_flags} = {flags_q, 1'b1};
        go();
        swap_flags = 1'b0;
        `CHK({flags_q, flags_alt_q}, {8'h00, e})
        put(cpu_flags_pkg::OP_ADD, 8'h09, 8'h08);
        put(cpu_flags_pkg::OP_DADJ, 8'h11, 8'h00);
        `CHK(result_q, 8'h17)
        give_verdict();
    end
endmodule : tb
